// >>> logic/epwm_unit.v
// Purpose: Enhanced PWM unit with four steered outputs and AHB-Lite registers.
// Assumes: One 10 MHz clock; sleep_i and port inputs come from the same domain.
// Notes:   Set ENHANCED to 0 for the basic single-pin instance.
`timescale 1ns/1ns
`include "epwm_consts.vh"

module epwm_unit #(
    parameter ENHANCED = 1
) (
    input  wire        clk_i,
    input  wire        nrst_i,
    input  wire        sleep_i,
    input  wire        hsel_i,
    input  wire [31:0] haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire [31:0] hwdata_i,
    input  wire        hready_i,
    output reg  [31:0] hrdata_o,
    output reg         hreadyout_o,
    output reg         hresp_o,
    input  wire [3:0]  port_data_i,
    output reg  [3:0]  pin_out_o,
    output reg  [3:0]  pin_oe_o,
    output reg  [3:0]  pwm_owned_o
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg  [7:0]  unit_control;
    reg  [7:0]  duty_high_byte;
    reg  [7:0]  period_limit;
    reg  [2:0]  timer_ctrl;
    reg         timebase_match_flag;
    reg  [3:0]  pin_direction;
    reg  [3:0]  steer_enable;
    reg  [9:0]  duty_shadow;
    reg         pwm_level;
    reg         pwm_armed;
    reg         start_pend;

    reg         wr_pend;
    reg  [7:0]  wr_addr;

    wire [7:0]  timebase_count;
    wire [1:0]  timebase_fine;
    wire        period_start;

    wire [1:0]  unit_mode_hi;
    wire        pwm_mode;
    wire [1:0]  output_config_sel;
    wire [1:0]  duty_low_bits;
    wire [9:0]  duty_next;
    wire [9:0]  timebase_full;
    wire        timebase_run;
    wire [1:0]  timebase_prescale_sel;
    wire        pol_ac_low;
    wire        pol_bd_low;
    wire        addr_ok;
    wire        match_clear;
    wire        start_now;

    reg  [3:0]  pin_active;
    reg  [3:0]  pin_used;
    reg  [31:0] next_rdata;
    reg  [3:0]  next_pin_out;
    reg  [3:0]  active_low;
    reg  [1:0]  cfg_eff;
    reg  [3:0]  steer_eff;
    wire        mod;

    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    assign unit_mode_hi          = unit_control[`EPWM_CTRL_MODE_HI:`EPWM_CTRL_MODE_LO];
    assign pwm_mode              = (unit_mode_hi == `EPWM_MODE_PWM);
    assign output_config_sel     = unit_control[`EPWM_CTRL_CFG_HI:`EPWM_CTRL_CFG_LO];
    assign duty_low_bits         = unit_control[`EPWM_CTRL_DLOW_HI:`EPWM_CTRL_DLOW_LO];
    assign duty_next             = {duty_high_byte, duty_low_bits};
    assign timebase_full         = {timebase_count, timebase_fine};
    assign timebase_run          = timer_ctrl[`EPWM_TMR_RUN];
    assign timebase_prescale_sel = timer_ctrl[`EPWM_TMR_PS_HI:`EPWM_TMR_PS_LO];
    assign pol_ac_low            = (ENHANCED != 0) && unit_control[`EPWM_CTRL_POL_AC];
    assign pol_bd_low            = (ENHANCED != 0) && unit_control[`EPWM_CTRL_POL_BD];

    // ----------------------------------------------------------------
    // Time base
    // ----------------------------------------------------------------
    epwm_timebase u_timebase (
        .clk_i          (clk_i),
        .nrst_i         (nrst_i),
        .run_i          (timebase_run),
        .hold_i         (sleep_i),
        .prescale_sel_i (timebase_prescale_sel),
        .period_i       (period_limit),
        .count_o        (timebase_count),
        .fine_o         (timebase_fine),
        .period_start_o (period_start)
    );

    // ----------------------------------------------------------------
    // AHB-Lite slave
    // ----------------------------------------------------------------
    assign addr_ok = hsel_i && hready_i && (htrans_i == `EPWM_HTRANS_NONSEQ
                     || htrans_i == 2'h3);

    always @* begin
        next_rdata = 32'h0000_0000;
        case (haddr_i[7:0])
            `EPWM_OFS_CTRL:      next_rdata[7:0] = unit_control;
            `EPWM_OFS_DUTY_HIGH: next_rdata[7:0] = duty_high_byte;
            `EPWM_OFS_PERIOD:    next_rdata[7:0] = period_limit;
            `EPWM_OFS_TIMER:     next_rdata[2:0] = timer_ctrl;
            `EPWM_OFS_STATUS:    next_rdata[0]   = timebase_match_flag;
            `EPWM_OFS_PIN_DIR:   next_rdata[3:0] = pin_direction;
            `EPWM_OFS_STEER:     next_rdata[3:0] = steer_enable;
            `EPWM_OFS_COUNT:     next_rdata[7:0] = timebase_count;
            `EPWM_OFS_SHADOW:    next_rdata[9:0] = duty_shadow;
            default:             next_rdata      = 32'h0000_0000;
        endcase
        if (haddr_i[31:8] != 24'h00_0000) begin
            next_rdata = 32'h0000_0000;
        end
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hrdata_o    <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            wr_pend     <= 1'b0;
            wr_addr     <= 8'h00;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            wr_pend     <= addr_ok && hwrite_i && (haddr_i[31:8] == 24'h00_0000);
            if (addr_ok) begin
                wr_addr <= haddr_i[7:0];
            end
            if (addr_ok && !hwrite_i) begin
                hrdata_o <= next_rdata;
            end
        end
    end

    assign match_clear = wr_pend && (wr_addr == `EPWM_OFS_STATUS)
                         && hwdata_i[`EPWM_STAT_MATCH];

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            unit_control   <= `EPWM_RST_BYTE;
            duty_high_byte <= `EPWM_RST_BYTE;
            period_limit   <= `EPWM_RST_PERIOD;
            timer_ctrl     <= 3'h0;
            pin_direction  <= `EPWM_RST_PIN_DIR;
            steer_enable   <= `EPWM_RST_STEER;
        end else if (wr_pend) begin
            case (wr_addr)
                `EPWM_OFS_CTRL:      unit_control   <= hwdata_i[7:0];
                `EPWM_OFS_DUTY_HIGH: duty_high_byte <= hwdata_i[7:0];
                `EPWM_OFS_PERIOD:    period_limit   <= hwdata_i[7:0];
                `EPWM_OFS_TIMER:     timer_ctrl     <= hwdata_i[2:0];
                `EPWM_OFS_PIN_DIR:   pin_direction  <= hwdata_i[3:0];
                `EPWM_OFS_STEER:     steer_enable   <= hwdata_i[3:0];
                default: begin
                end
            endcase
        end
    end

    // Match flag: a new period start wins over a clear in the same cycle
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timebase_match_flag <= 1'b0;
        end else if (period_start) begin
            timebase_match_flag <= 1'b1;
        end else if (match_clear) begin
            timebase_match_flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Duty engine
    // ----------------------------------------------------------------
    // A period start that meets the first sleep cycle is kept until wake-up
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            start_pend <= 1'b0;
        end else if (sleep_i) begin
            start_pend <= start_pend || period_start;
        end else begin
            start_pend <= 1'b0;
        end
    end

    assign start_now = period_start || start_pend;

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            duty_shadow <= 10'h000;
            pwm_level   <= 1'b0;
            pwm_armed   <= 1'b0;
        end else if (!sleep_i) begin
            if (!pwm_mode) begin
                pwm_armed <= 1'b0;
                pwm_level <= 1'b0;
            end else if (start_now) begin
                duty_shadow <= duty_next;
                pwm_level   <= (duty_next != 10'h000);
                pwm_armed   <= 1'b1;
            end else if (timebase_full == duty_shadow) begin
                pwm_level <= 1'b0;
            end
        end
    end

    assign mod = pwm_armed && pwm_level;

    // ----------------------------------------------------------------
    // Output steering
    // ----------------------------------------------------------------
    always @* begin
        if (ENHANCED != 0) begin
            cfg_eff   = output_config_sel;
            steer_eff = steer_enable;
        end else begin
            cfg_eff   = `EPWM_CFG_SINGLE;
            steer_eff = 4'h1;
        end
        pin_active = 4'h0;
        pin_used   = 4'h0;
        case (cfg_eff)
            `EPWM_CFG_SINGLE: begin
                if (steer_eff == 4'h0) begin
                    pin_used   = 4'h1;
                    pin_active = {3'h0, mod};
                end else begin
                    pin_used   = steer_eff;
                    pin_active = steer_eff & {4{mod}};
                end
            end
            `EPWM_CFG_HALF: begin
                pin_used   = 4'h3;
                pin_active = {2'h0, !mod && pwm_armed, mod};
            end
            `EPWM_CFG_FWD: begin
                pin_used   = 4'hf;
                pin_active = {mod, 2'h0, pwm_armed};
            end
            `EPWM_CFG_REV: begin
                pin_used   = 4'hf;
                pin_active = {1'b0, pwm_armed, mod, 1'b0};
            end
            default: begin
                pin_used   = 4'h0;
                pin_active = 4'h0;
            end
        endcase
        if (!pwm_mode) begin
            pin_used = 4'h0;
        end
        active_low = {pol_bd_low, pol_ac_low, pol_bd_low, pol_ac_low};
    end

    // ----------------------------------------------------------------
    // Pin drivers, one slice per pin
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
            always @* begin
                if (pin_used[gi]) begin
                    next_pin_out[gi] = pin_active[gi] ^ active_low[gi];
                end else begin
                    next_pin_out[gi] = port_data_i[gi];
                end
            end

            always @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    pin_out_o[gi]   <= 1'b0;
                    pin_oe_o[gi]    <= 1'b0;
                    pwm_owned_o[gi] <= 1'b0;
                end else if (!sleep_i) begin
                    pin_out_o[gi]   <= next_pin_out[gi];
                    pin_oe_o[gi]    <= !pin_direction[gi];
                    pwm_owned_o[gi] <= pin_used[gi];
                end
            end
        end
    endgenerate

endmodule

// >>> logic/epwm_consts.vh
// Purpose: Constants of the enhanced PWM output block: offsets, fields, resets.
// Assumes: AHB-Lite slave, 32-bit words, byte offsets below.
// Notes:   Definitions only.
//
// What this block does
// - In sleep the time base and all PWM state stay frozen.
// - In sleep every driven PWM pin keeps its present level.
// - After sleep the time base resumes from its held count.
// - The time base counts system clock cycles, so frequency scales with it.
// - Reset sets all pins to input and every register to its reset value.
// - Ten-bit PWM on up to four pins per the output configuration.
// - Config field: 00 single, 10 half-bridge, 01 forward, 11 reverse.
// - Only instances with ENHANCED nonzero offer multi-output modes; others are single pin.
// - Mode bits choose active-high or active-low drive per pin pair.
// - After enabling, output waits for a new period to start.
// - Control register zero releases all pins to the port logic.
// - Pins unused by the configuration are left to the port logic.
// - Single mode drives the pins whose steering enable is set, or pin A alone when no enable is set.
// - Count equal to period: clear count, set output unless duty zero, latch duty.
// - Ten-bit duty: high byte plus two control bits, buffered to period end.
// - Half-bridge: A modulated, B its complement.
// - Forward: A active, D modulated; reverse: C active, B modulated.
`ifndef EPWM_CONSTS_VH
`define EPWM_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define EPWM_OFS_CTRL      8'h00
`define EPWM_OFS_DUTY_HIGH 8'h04
`define EPWM_OFS_PERIOD    8'h08
`define EPWM_OFS_TIMER     8'h0c
`define EPWM_OFS_STATUS    8'h10
`define EPWM_OFS_PIN_DIR   8'h14
`define EPWM_OFS_STEER     8'h18
`define EPWM_OFS_COUNT     8'h1c
`define EPWM_OFS_SHADOW    8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EPWM_CTRL_CFG_HI   7
`define EPWM_CTRL_CFG_LO   6
`define EPWM_CTRL_DLOW_HI  5
`define EPWM_CTRL_DLOW_LO  4
`define EPWM_CTRL_POL_AC   1
`define EPWM_CTRL_POL_BD   0
`define EPWM_CTRL_MODE_HI  3
`define EPWM_CTRL_MODE_LO  2
`define EPWM_TMR_RUN       2
`define EPWM_TMR_PS_HI     1
`define EPWM_TMR_PS_LO     0
`define EPWM_STAT_MATCH    0

// ----------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------
`define EPWM_MODE_PWM      2'h3
`define EPWM_CFG_SINGLE    2'h0
`define EPWM_CFG_FWD       2'h1
`define EPWM_CFG_HALF      2'h2
`define EPWM_CFG_REV       2'h3
`define EPWM_PS_1          2'h0
`define EPWM_PS_4          2'h1
`define EPWM_PRE_LAST_1    6'h03
`define EPWM_PRE_LAST_4    6'h0f
`define EPWM_PRE_LAST_16   6'h3f
`define EPWM_RST_BYTE      8'h00
`define EPWM_RST_PERIOD    8'hff
`define EPWM_RST_PIN_DIR   4'hf
`define EPWM_RST_STEER     4'h1
`define EPWM_HTRANS_NONSEQ 2'h2

`endif

// >>> logic/epwm_timebase.v
// Purpose: Prescaled 8-bit time base with 2-bit fine extension.
// Assumes: Same clock as the register file.
// Notes:   Holds the prescaler and count while hold_i is high; period_start_o still clears.
`timescale 1ns/1ns
`include "epwm_consts.vh"

module epwm_timebase (
    input  wire       clk_i,
    input  wire       nrst_i,
    input  wire       run_i,
    input  wire       hold_i,
    input  wire [1:0] prescale_sel_i,
    input  wire [7:0] period_i,
    output reg  [7:0] count_o,
    output reg  [1:0] fine_o,
    output reg        period_start_o
);

    reg  [5:0] pre;
    reg  [5:0] pre_last;

    always @* begin
        case (prescale_sel_i)
            `EPWM_PS_1: pre_last = `EPWM_PRE_LAST_1;
            `EPWM_PS_4: pre_last = `EPWM_PRE_LAST_4;
            default:    pre_last = `EPWM_PRE_LAST_16;
        endcase
    end

    always @* begin
        case (prescale_sel_i)
            `EPWM_PS_1: fine_o = pre[1:0];
            `EPWM_PS_4: fine_o = pre[3:2];
            default:    fine_o = pre[5:4];
        endcase
    end

    // ----------------------------------------------------------------
    // Counter: one step per 4 x prescale system clocks
    // ----------------------------------------------------------------
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pre            <= 6'h00;
            count_o        <= 8'h00;
            period_start_o <= 1'b0;
        end else begin
            period_start_o <= 1'b0;
            if (run_i && !hold_i) begin
                if (pre >= pre_last) begin
                    pre <= 6'h00;
                    if (count_o == period_i) begin
                        count_o        <= 8'h00;
                        period_start_o <= 1'b1;
                    end else begin
                        count_o <= count_o + 8'h01;
                    end
                end else begin
                    pre <= pre + 6'h01;
                end
            end
        end
    end

endmodule

// >>> tb/epwm_checker.sv
// Purpose: Concurrent checks on the enhanced PWM unit ports.
// Assumes: Control register mirrored from AHB write data phases.
// Notes:   Bound to every epwm_unit instance.
`timescale 1ns/1ns
module epwm_checker (
    input wire        clk_i,
    input wire        nrst_i,
    input wire        sleep_i,
    input wire        hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0]  htrans_i,
    input wire        hwrite_i,
    input wire [31:0] hwdata_i,
    input wire        hready_i,
    input wire        hreadyout_o,
    input wire        hresp_o,
    input wire [3:0]  port_data_i,
    input wire [3:0]  pin_out_o,
    input wire [3:0]  pin_oe_o,
    input wire [3:0]  pwm_owned_o
);
    reg       wr_ctrl;
    reg [7:0] ctrl;
    // ------------------------------------------------------------
    // Mirror of the control register
    // ------------------------------------------------------------
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ctrl <= 1'b0;
            ctrl <= 8'h00;
        end else if (hready_i) begin
            wr_ctrl <= hsel_i && htrans_i[1] && hwrite_i && haddr_i == 32'h0;
            if (wr_ctrl) begin
                ctrl <= hwdata_i[7:0];
            end
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence s_held;
        (!sleep_i && $stable(ctrl) && ctrl[3:2] == 2'h3)[*4];
    endsequence
    sequence s_quiet;
        (!sleep_i && $stable(port_data_i) && $stable(pwm_owned_o))[*3];
    endsequence
    property p_bus;
        hreadyout_o && !hresp_o;
    endproperty
    property p_rst;
        $rose(nrst_i) |-> (pin_oe_o == 4'h0 && pwm_owned_o == 4'h0 && pin_out_o == 4'h0);
    endproperty
    property p_sleep;
        sleep_i |=> $stable(pin_out_o);
    endproperty
    property p_port;
        s_quiet |-> ((pin_out_o ^ port_data_i) & ~pwm_owned_o) == 4'h0;
    endproperty
    property p_own;
        s_held ##0 (ctrl[7:6] != 2'h0) |-> pwm_owned_o == (ctrl[7:6] == 2'h2 ? 4'h3 : 4'hf);
    endproperty
    property p_half;
        s_held ##0 (ctrl[7:6] == 2'h2 && ctrl[1:0] == 2'h0) |-> !(pin_out_o[0] && pin_out_o[1]);
    endproperty
    property p_fwd;
        s_held ##0 (ctrl[7:6] == 2'h1 && ctrl[1:0] == 2'h0) |-> pin_out_o[2:1] == 2'h0;
    endproperty
    property p_rev;
        s_held ##0 (ctrl[7:6] == 2'h3 && ctrl[1:0] == 2'h0) |-> !(pin_out_o[0] || pin_out_o[3]);
    endproperty
    a_bus: assert property (p_bus) else $error("bus slave not ready or error");
    a_rst: assert property (p_rst) else $error("pins not released by reset");
    a_sleep: assert property (p_sleep) else $error("pin moved in sleep");
    a_port: assert property (p_port) else $error("unowned pin not port data");
    a_own: assert property (p_own) else $error("wrong pin ownership");
    a_half: assert property (p_half) else $error("half bridge pins both on");
    a_fwd: assert property (p_fwd) else $error("forward B or C active");
    a_rev: assert property (p_rev) else $error("reverse A or D active");
endmodule

bind epwm_unit epwm_checker u_chk (
    .clk_i(clk_i), .nrst_i(nrst_i), .sleep_i(sleep_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .port_data_i(port_data_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .pwm_owned_o(pwm_owned_o)
);

// >>> tb/epwm_switch_model.sv
// Purpose: Switch driver stage seen by the four PWM pins.
// Assumes: Released pins sit on external pull-downs.
// Notes:   Pad level is what the gate drivers see.
`timescale 1ns/1ns
module epwm_switch_model (
    input  wire [3:0] pin_out_i,
    input  wire [3:0] pin_oe_i,
    output wire [3:0] pad_o
);
    // Released pins fall to the pull-down, keeping switches off
    assign pad_o = pin_out_i & pin_oe_i;
endmodule

// >>> tb/test_enhanced_pwm_output_control.sv
// Purpose: Self-checking bench for the enhanced PWM output block.
// Assumes: Zero-wait AHB-Lite slave, 10 MHz clock.
// Notes:   Pin levels are measured at the switch driver pads.
`timescale 1ns/1ns
`include "epwm_consts.vh"
module test_enhanced_pwm_output_control;
    localparam integer D = 6;
    localparam integer W = 32;
    // Per-mode tables, entry m in bits [n*m +: n], first mode in the low bits
    localparam [47:0] CF = {8'hec, 8'h6c, 8'haf, 8'hac, 8'h2c, 8'h2c};
    localparam [23:0] ST = {4'h1, 4'h1, 4'h1, 4'h1, 4'h0, 4'h5};
    localparam [23:0] OW = {4'hf, 4'hf, 4'h3, 4'h3, 4'h1, 4'h5};
    localparam [47:0] EA = {8'h00, 8'h20, 8'h1a, 8'h06, 8'h06, 8'h06};
    localparam [47:0] EB = {8'h06, 8'h00, 8'h06, 8'h1a, 8'h00, 8'h00};
    localparam [47:0] EC = {8'h20, 8'h00, 8'h20, 8'h20, 8'h20, 8'h06};
    localparam [47:0] ED = {8'h00, 8'h06, 8'h20, 8'h20, 8'h20, 8'h20};
    reg         clk_i, nrst_i, sleep_i, hsel_i, hwrite_i;
    reg  [31:0] haddr_i, hwdata_i, q, c1;
    reg  [1:0]  htrans_i;
    reg  [2:0]  hsize_i;
    reg  [3:0]  port_data_i, own, pv;
    wire [31:0] hrdata_o;
    wire        hreadyout_o, hresp_o;
    wire [3:0]  pin_out_o, pin_oe_o, pwm_owned_o, pad;
    integer     num_errors, n_tests, m, p, cnt [4];

    epwm_unit DUT (
        .clk_i(clk_i), .nrst_i(nrst_i), .sleep_i(sleep_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .port_data_i(port_data_i),
        .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pwm_owned_o(pwm_owned_o)
    );
    epwm_switch_model u_sw (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .pad_o(pad));

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task xfer(input [7:0] a, input w, input [31:0] d);
        begin
            haddr_i <= {24'h0, a};
            hwrite_i <= w;
            htrans_i <= `EPWM_HTRANS_NONSEQ;
            do @(posedge clk_i); while (hreadyout_o !== 1'b1);
            htrans_i <= 2'h0;
            hwdata_i <= d;
            do @(posedge clk_i); while (hreadyout_o !== 1'b1);
            q = hrdata_o;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task rd(input [7:0] a);
        xfer(a, 1'b0, 32'h0);
    endtask
    task chk(input [31:0] g, input [31:0] e);
        begin
            n_tests++;
            if (g !== e) begin
                num_errors++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task rc(input [7:0] a, input [31:0] e);
        begin
            rd(a);
            chk(q, e);
        end
    endtask
    // Clears the match flag, then polls until a new period starts
    task wait_match;
        integer k;
        begin
            wr(`EPWM_OFS_STATUS, 32'h1);
            q = 32'h0;
            for (k = 0; k < 400 && q[0] !== 1'b1; k++)
                rd(`EPWM_OFS_STATUS);
            chk(q[0], 1'b1);
        end
    endtask
    // High cycles of each pad over a window
    task meas(input integer w);
        integer i, b;
        begin
            for (b = 0; b < 4; b++)
                cnt[b] = 0;
            for (i = 0; i < w; i++) begin
                @(negedge clk_i);
                own = pwm_owned_o;
                for (b = 0; b < 4; b++)
                    cnt[b] += pad[b];
            end
            @(posedge clk_i);
        end
    endtask
    task finish_test;
        begin
            $display("Checks %0d, mismatches %0d", n_tests, num_errors);
            if (num_errors == 0 && n_tests > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        #(100 * 40000);
        num_errors++;
        finish_test;
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {nrst_i, sleep_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = 0;
        {hsel_i, hsize_i, port_data_i, num_errors, n_tests} = {1'b1, 3'h2, 4'hc, 64'h0};
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        rc(`EPWM_OFS_PERIOD, `EPWM_RST_PERIOD);
        rc(`EPWM_OFS_PIN_DIR, `EPWM_RST_PIN_DIR);
        rc(`EPWM_OFS_STEER, `EPWM_RST_STEER);
        rc(`EPWM_OFS_CTRL, 32'h0);
        wr(8'h40, 32'hffffffff);
        rc(8'h40, 32'h0);
        chk(pin_oe_o, 4'h0);
        $display("Test reset done");
        wr(`EPWM_OFS_PIN_DIR, 32'hf);
        wr(`EPWM_OFS_PERIOD, 32'h7);
        wr(`EPWM_OFS_CTRL, 32'h2c);
        wr(`EPWM_OFS_DUTY_HIGH, 32'h1);
        wr(`EPWM_OFS_STATUS, 32'h1);
        wr(`EPWM_OFS_TIMER, 32'h4);
        @(negedge clk_i);
        chk(pin_out_o[0], 1'b0);
        chk(pwm_owned_o[0], 1'b1);
        @(posedge clk_i);
        wait_match;
        wr(`EPWM_OFS_PIN_DIR, 32'h0);
        rc(`EPWM_OFS_SHADOW, 32'h6);
        chk(pin_oe_o, 4'hf);
        $display("Test setup done");
        for (p = 2; p >= 0; p--) begin
            wr(`EPWM_OFS_TIMER, 32'h4 | p);
            wait_match;
            meas(W << (2 * p));
            chk(cnt[0], D << (2 * p));
        end
        $display("Test prescale done");
        for (m = 0; m < 6; m++) begin
            wr(`EPWM_OFS_STEER, ST[4*m +: 4]);
            wr(`EPWM_OFS_CTRL, CF[8*m +: 8]);
            wait_match;
            wait_match;
            meas(W);
            chk(own, OW[4*m +: 4]);
            chk(cnt[0], EA[8*m +: 8]);
            chk(cnt[1], EB[8*m +: 8]);
            chk(cnt[2], EC[8*m +: 8]);
            chk(cnt[3], ED[8*m +: 8]);
        end
        $display("Test modes done");
        wr(`EPWM_OFS_DUTY_HIGH, 32'h0);
        wr(`EPWM_OFS_CTRL, 32'h0c);
        wait_match;
        wait_match;
        meas(W);
        chk(cnt[0], 0);
        wait_match;
        wr(`EPWM_OFS_DUTY_HIGH, 32'h1);
        rc(`EPWM_OFS_SHADOW, 32'h0);
        wait_match;
        rc(`EPWM_OFS_SHADOW, 32'h4);
        $display("Test duty buffer done");
        sleep_i <= 1'b1;
        rd(`EPWM_OFS_COUNT);
        c1 = q;
        @(negedge clk_i);
        pv = pad;
        repeat (20) @(posedge clk_i);
        rc(`EPWM_OFS_COUNT, c1);
        chk(pad, pv);
        sleep_i <= 1'b0;
        rd(`EPWM_OFS_COUNT);
        chk(q, c1);
        rd(`EPWM_OFS_COUNT);
        chk(q == c1 || q == ((c1 + 1) & 32'h7), 1'b1);
        $display("Test sleep done");
        wr(`EPWM_OFS_CTRL, 32'h0);
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        chk(pwm_owned_o, 4'h0);
        chk(pin_out_o, port_data_i);
        @(posedge clk_i);
        $display("Test release done");
        nrst_i <= 1'b0;
        @(negedge clk_i);
        chk(pin_oe_o, 4'h0);
        @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        rc(`EPWM_OFS_PIN_DIR, `EPWM_RST_PIN_DIR);
        rc(`EPWM_OFS_PERIOD, `EPWM_RST_PERIOD);
        $display("Test second reset done");
        finish_test;
    end
endmodule
